// File: serial_port_pkg.sv
package serial_port_pkg;

  // ==========================================================================
  // data and pin layout
  // ==========================================================================
  localparam int BYTE_W    = 8;
  localparam int NUM_PINS  = 4;
  localparam int PIN_CLK   = 0;   // sck in spi, scl in i2c
  localparam int PIN_DIN   = 1;   // sdi in spi, sda in i2c
  localparam int PIN_DOUT  = 2;   // sdo, spi only
  localparam int PIN_SEL   = 3;   // slave select, spi only
  localparam int CNT_W     = 4;

  localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;  // eighth data bit
  localparam logic [CNT_W-1:0] ACK_BIT  = 4'h8;  // i2c acknowledge slot

  // pins owned by the port in each protocol
  localparam logic [NUM_PINS-1:0] SPI_PIN_MASK = 4'hf;
  localparam logic [NUM_PINS-1:0] I2C_PIN_MASK = 4'h3;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [BYTE_W-1:0]   BYTE_RST = 8'h00;
  localparam logic [NUM_PINS-1:0] PIN_RST  = 4'h0;

  // ==========================================================================
  // master clock timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS   = 80;
  // least time, so round up
  localparam int SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SCK_HALF_LAST = 8'(SCK_HALF_CYC - 1);

  typedef enum logic {M_IDLE, M_RUN} master_state_e;

endpackage

// File: serial_port_enable_overflow.sv
`timescale 1ns/1ps
// Notes on behaviour
// - spi: byte completing while both buffer entries are unread sets the overflow flag
// - overflow flag is raised only as slave, never in master operation
// - master transfers start only on a software buffer write
// - overflow flag stays set until software clears it
// - enable set in spi: port owns clock, data out, data in, select
// - enable clear: port off, pins return to general purpose use
// - enable set in i2c: port owns data and clock pins
// - i2c: byte arriving while buffer full sets overflow flag
module serial_port_enable_overflow
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_arst_n,
  // control
  input  wire logic                i_port_enable_bit,
  input  wire logic                i_i2c_mode,
  input  wire logic                i_master_mode,
  input  wire logic                i_sel_ctrl_en,
  input  wire logic                i_overflow_clear,
  input  wire logic [NUM_PINS-1:0] i_pin_dir_out,
  // general purpose pin drive
  input  wire logic [NUM_PINS-1:0] i_gpio_out,
  input  wire logic [NUM_PINS-1:0] i_gpio_oe,
  // pins
  input  wire logic [NUM_PINS-1:0] i_pin_in,
  output logic      [NUM_PINS-1:0] o_pin_out,
  output logic      [NUM_PINS-1:0] o_pin_oe,
  // transmit write
  input  wire logic                i_tx_valid,
  input  wire logic [BYTE_W-1:0]   i_tx_data,
  output logic                     o_tx_ready,
  // received bytes
  output logic                     o_rx_valid,
  output logic      [BYTE_W-1:0]   o_rx_data,
  input  wire logic                i_rx_ready,
  // status
  output logic                     o_receive_overflow_flag,
  output logic                     o_port_active
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic [NUM_PINS-1:0] pin_prev_reg;

  // only pin_sync_reg reads pin_meta_reg
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta_reg <= PIN_RST;
      pin_sync_reg <= PIN_RST;
      pin_prev_reg <= PIN_RST;
    end else begin
      pin_meta_reg <= i_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic i2c_start;
  assign clk_rise  = pin_sync_reg[PIN_CLK] & ~pin_prev_reg[PIN_CLK];
  assign clk_fall  = ~pin_sync_reg[PIN_CLK] & pin_prev_reg[PIN_CLK];
  // sda falls while scl high: start condition realigns the bit count
  assign i2c_start = pin_sync_reg[PIN_CLK] & pin_prev_reg[PIN_CLK] &
                     pin_prev_reg[PIN_DIN] & ~pin_sync_reg[PIN_DIN];

  // ==========================================================================
  // mode decode
  // ==========================================================================
  logic spi_on;
  logic i2c_on;
  logic is_master;
  logic sel_ok;
  assign spi_on    = i_port_enable_bit & ~i_i2c_mode;
  assign i2c_on    = i_port_enable_bit & i_i2c_mode;
  assign is_master = spi_on & i_master_mode;
  assign sel_ok    = ~i_sel_ctrl_en | ~pin_sync_reg[PIN_SEL];

  // ==========================================================================
  // master clock generator
  // ==========================================================================
  master_state_e m_state_reg;
  master_state_e m_state_next;
  logic [7:0]    div_reg;
  logic          sck_reg;
  logic          m_tick;
  logic          m_start;
  logic          m_done;

  assign m_tick  = (m_state_reg == M_RUN) && (div_reg == SCK_HALF_LAST);
  // a master byte begins only on an accepted buffer write
  assign m_start = is_master && i_tx_valid && o_tx_ready;

  // half period divider; enable pulse toggles the generated clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
    end else if (m_state_reg != M_RUN || m_tick) begin
      div_reg <= 8'h00;
      sck_reg <= m_tick & ~sck_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_comb begin
    m_state_next = m_state_reg;
    unique case (m_state_reg)
      M_IDLE: begin
        if (m_start) begin
          m_state_next = M_RUN;
        end
      end
      M_RUN: begin
        if (!is_master || m_done) begin
          m_state_next = M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      m_state_reg <= M_IDLE;
    end else begin
      m_state_reg <= m_state_next;
    end
  end

  // ==========================================================================
  // bit sampling and shifting
  // ==========================================================================
  logic              sample;
  logic              shift_out;
  logic              rx_active;
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic [BYTE_W-1:0] receive_shift_register;
  logic [BYTE_W-1:0] tx_shift_reg;
  logic              byte_done_reg;

  assign rx_active = is_master ? (m_state_reg == M_RUN)
                   : (i2c_on | (spi_on & sel_ok));
  assign sample    = is_master ? (m_tick & ~sck_reg)
                   : (rx_active & clk_rise);
  assign shift_out = is_master ? (m_tick & sck_reg)
                   : (spi_on & sel_ok & clk_fall);
  // master ends on the falling edge after its eighth sample
  assign m_done    = shift_out && is_master && (bit_cnt_reg == ACK_BIT);

  // receive shift and bit count; i2c skips the acknowledge slot
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt_reg            <= '0;
      receive_shift_register <= BYTE_RST;
      byte_done_reg          <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      if (!rx_active || (i2c_on && i2c_start) || m_done) begin
        bit_cnt_reg <= '0;
      end else if (sample) begin
        if (i2c_on && bit_cnt_reg == ACK_BIT) begin
          bit_cnt_reg <= '0;
        end else begin
          receive_shift_register <= {receive_shift_register[BYTE_W-2:0],
                                     pin_sync_reg[PIN_DIN]};
          byte_done_reg <= (bit_cnt_reg == LAST_BIT);
          if (bit_cnt_reg == LAST_BIT && !i2c_on && !is_master) begin
            bit_cnt_reg <= '0;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      end
    end
  end

  // transmit shift: loaded by a buffer write, msb first
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_shift_reg <= BYTE_RST;
    end else if (i_tx_valid && o_tx_ready) begin
      tx_shift_reg <= i_tx_data;
    end else if (shift_out && !m_done) begin
      tx_shift_reg <= {tx_shift_reg[BYTE_W-2:0], 1'b0};
    end
  end

  // ==========================================================================
  // two-entry receive buffer (head is the buffer register)
  // ==========================================================================
  logic [BYTE_W-1:0] tail_data_reg;
  logic              tail_valid_reg;
  logic              pop;
  logic              full;
  logic              push;
  logic              head_valid_next;
  logic              tail_valid_next;

  assign pop  = o_rx_valid & i_rx_ready;
  assign full = o_rx_valid & tail_valid_reg;
  // a full buffer refuses the byte unless a pop frees a slot in the same cycle; the unread data is kept
  assign push = byte_done_reg & (~full | pop);

  always_comb begin
    head_valid_next = o_rx_valid;
    tail_valid_next = tail_valid_reg;
    if (pop) begin
      head_valid_next = tail_valid_reg;
      tail_valid_next = 1'b0;
    end
    if (push && !head_valid_next) begin
      head_valid_next = 1'b1;
    end else if (push) begin
      tail_valid_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_valid     <= 1'b0;
      o_rx_data      <= BYTE_RST;
      tail_valid_reg <= 1'b0;
      tail_data_reg  <= BYTE_RST;
    end else begin
      o_rx_valid     <= head_valid_next;
      tail_valid_reg <= tail_valid_next;
      if (pop && tail_valid_reg) begin
        o_rx_data <= tail_data_reg;
      end else if (push && (!o_rx_valid || pop)) begin
        o_rx_data <= receive_shift_register;
      end
      if (push && tail_valid_next) begin
        tail_data_reg <= receive_shift_register;
      end
    end
  end

  // write acceptance; master waits for a free slot so a byte cannot be lost
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= ~m_start & spi_on & (~i_master_mode |
                    ((m_state_next == M_IDLE) & ~tail_valid_next));
    end
  end

  // ==========================================================================
  // overflow flag
  // ==========================================================================
  // slave only, spi or i2c; a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_receive_overflow_flag <= 1'b0;
    end else if (byte_done_reg && !push && !is_master) begin
      o_receive_overflow_flag <= 1'b1;
    end else if (i_overflow_clear) begin
      o_receive_overflow_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // pin ownership
  // ==========================================================================
  logic [NUM_PINS-1:0] port_out;
  logic [NUM_PINS-1:0] own_mask;
  // i2c only listens here, so its pins stay undriven (inputs)
  assign port_out = {1'b0, tx_shift_reg[BYTE_W-1], 1'b0, sck_reg};
  assign own_mask = spi_on ? SPI_PIN_MASK
                  : (i2c_on ? I2C_PIN_MASK : PIN_RST);

  // owned pins follow the port with software direction in spi, undriven in i2c; others are gpio
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_out     <= PIN_RST;
      o_pin_oe      <= PIN_RST;
      o_port_active <= 1'b0;
    end else begin
      o_pin_out     <= (own_mask & port_out) |
                       (~own_mask & i_gpio_out);
      o_pin_oe      <= (own_mask & i_pin_dir_out & ~{NUM_PINS{i2c_on}}) |
                       (~own_mask & i_gpio_oe);
      o_port_active <= i_port_enable_bit;
    end
  end

endmodule // serial_port_enable_overflow

// File: serial_port_checker_assertions.sv
`timescale 1ns/1ps
module serial_port_checker
  import serial_port_pkg::*;
(
  // clock, reset and controls
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_port_enable_bit,
  input wire logic       i_i2c_mode,
  input wire logic       i_master_mode,
  input wire logic       i_overflow_clear,
  input wire logic [3:0] i_pin_dir_out,
  input wire logic [3:0] i_gpio_out,
  input wire logic [3:0] i_gpio_oe,
  input wire logic       i_tx_valid,
  // outputs
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe,
  input wire logic       o_tx_ready,
  input wire logic       o_rx_valid,
  input wire logic       o_receive_overflow_flag,
  input wire logic       o_port_active
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic spi_m = i_port_enable_bit & i_master_mode & ~i_i2c_mode;
  wire logic ovf   = o_receive_overflow_flag;
  logic [1:0] up_reg;
  // pin checks wait three edges: $past must not see reset-time inputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  // ==========================================================================
  // assertions
  a_ovf_not_master: assert property ($rose(ovf) |-> !$past(spi_m))
    else $error("overflow raised as master");
  a_ovf_buf_full: assert property ($rose(ovf) |-> $past(o_rx_valid))
    else $error("overflow with empty buffer");
  a_ovf_sticky: assert property (ovf && !i_overflow_clear |=> ovf)
    else $error("overflow dropped by itself");
  a_ovf_clear: assert property ($fell(ovf) |->
    $past(i_overflow_clear))
    else $error("overflow fell without clear");
  a_pins_gpio: assert property (up_reg == 2'h3
    && !$past(i_port_enable_bit)
    |-> o_pin_oe == $past(i_gpio_oe) && o_pin_out == $past(i_gpio_out))
    else $error("gpio not restored");
  a_pins_spi: assert property (up_reg == 2'h3
    && $past(i_port_enable_bit & ~i_i2c_mode)
    |-> o_pin_oe == $past(i_pin_dir_out))
    else $error("spi pin enables wrong");
  a_pins_i2c: assert property (up_reg == 2'h3
    && $past(i_port_enable_bit & i_i2c_mode)
    |-> o_pin_oe == {$past(i_gpio_oe[3:2]), 2'b00})
    else $error("i2c pin enables wrong");
  a_active_copy: assert property (up_reg == 2'h3
    |-> o_port_active == $past(i_port_enable_bit))
    else $error("active flag wrong");
  a_master_busy: assert property (i_tx_valid && o_tx_ready && spi_m
    |=> !o_tx_ready [*8])
    else $error("master ready during transfer");
  // main scenarios
  c_overflow: cover property ($rose(ovf));
  c_rx_pop: cover property (o_rx_valid ##1 !o_rx_valid);
  c_master_write: cover property (i_tx_valid && o_tx_ready && spi_m);
endmodule // serial_port_checker

bind serial_port_enable_overflow serial_port_checker u_serial_port_checker (
  .i_clk, .i_arst_n, .i_port_enable_bit, .i_i2c_mode, .i_master_mode,
  .i_overflow_clear, .i_pin_dir_out, .i_gpio_out, .i_gpio_oe, .i_tx_valid,
  .o_pin_out, .o_pin_oe, .o_tx_ready, .o_rx_valid, .o_receive_overflow_flag,
  .o_port_active);

// File: serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // lines driven toward the port
  output logic o_clk_line,
  output logic o_data_line,
  output logic o_sel_n
);
  realtime half = 62.5;  // 125 ns link clock, stands still between frames
  // ==========================================================================
  // idle lines
  initial begin
    o_clk_line  = 1'b0;
    o_data_line = 1'b1;
    o_sel_n     = 1'b1;
  end
  // one byte msb first; i2c adds start, released ack slot and stop
  task automatic xfer(input logic [7:0] b, input bit i2c);
    o_clk_line = i2c;
    #half;
    if (i2c) o_data_line = 1'b0;
    else o_sel_n = 1'b0;
    #half;
    o_clk_line = 1'b0;
    for (int k = 0; k < 9; k++) begin
      if (k == 8 && !i2c) break;
      o_data_line = (k < 8) ? b[7-k] : 1'b1;  // ack left to the pull-up
      #half;
      o_clk_line = 1'b1;
      #half;
      o_clk_line = 1'b0;
    end
    if (i2c) begin
      o_data_line = 1'b0;
      #half;
      o_clk_line = 1'b1;
      #half;
      o_data_line = 1'b1;
    end else begin
      o_sel_n = 1'b1;
      o_data_line = ~o_data_line;  // released line must not hold old bit
    end
    #half;
  endtask
endmodule // serial_peer

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top
  import serial_port_pkg::*;
;
  logic            i_clk, i_arst_n, en, i2c, mst, clr, txv, rxr;
  logic [3:0]      dir, gout, goe, pout, poe;
  logic [7:0]      txd, rxd;
  logic            txr, rxv, ovf, act;
  wire logic       cl, dl, sn;
  wire logic [3:0] pins = (poe & pout) | (~poe & {sn, ~dl, dl, cl});
  int              n_fail = 0;
  int              check_count = 0;
  // ==========================================================================
  // design and far side
  serial_port_enable_overflow u_serial_port_enable_overflow (
    .i_clk, .i_arst_n, .i_port_enable_bit(en), .i_i2c_mode(i2c),
    .i_master_mode(mst), .i_sel_ctrl_en(1'b1), .i_overflow_clear(clr),
    .i_pin_dir_out(dir), .i_gpio_out(gout), .i_gpio_oe(goe), .i_pin_in(pins),
    .o_pin_out(pout), .o_pin_oe(poe), .i_tx_valid(txv), .i_tx_data(txd),
    .o_tx_ready(txr), .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rxr),
    .o_receive_overflow_flag(ovf), .o_port_active(act));
  serial_peer u_serial_peer (.o_clk_line(cl), .o_data_line(dl), .o_sel_n(sn));
  // 100 MHz
  always #5 i_clk = ~i_clk;
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cfg(input logic e, i, m, input logic [3:0] d);
    @(posedge i_clk) en <= e;
    i2c <= i;
    mst <= m;
    dir <= d;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic wait_rx;
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge i_clk);
      if (rxv === 1'b1) break;
    end
    if (k == 400) begin
      n_fail++;
      final_report();
    end
  endtask
  // sampled at the negedge so the read does not race the pop edge
  task automatic pop(output logic [7:0] d);
    wait_rx();
    d = rxd;
    @(posedge i_clk) rxr <= 1'b1;
    @(posedge i_clk) rxr <= 1'b0;
  endtask
  task automatic put(input logic [7:0] b);
    int k;
    @(posedge i_clk) txv <= 1'b1;
    txd <= b;
    for (k = 0; k < 400; k++) begin
      @(negedge i_clk);
      if (txr === 1'b1) break;
    end
    if (k == 400) begin
      n_fail++;
      final_report();
    end
    @(posedge i_clk) txv <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic clear;
    @(posedge i_clk) clr <= 1'b1;
    @(posedge i_clk) clr <= 1'b0;
    @(negedge i_clk);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_spi_slave;
    logic [7:0] d;
    cfg(1'b1, 1'b0, 1'b0, 4'h4);
    chk(8'(poe), 8'h04);
    chk(8'(act), 8'h01);
    u_serial_peer.xfer(8'ha5, 1'b0);
    u_serial_peer.xfer(8'h3c, 1'b0);
    u_serial_peer.xfer(8'h81, 1'b0);
    repeat (8) @(negedge i_clk);
    chk(8'(ovf), 8'h01);
    pop(d);
    chk(d, 8'ha5);
    pop(d);
    chk(d, 8'h3c);
    chk(8'(ovf), 8'h01);
    clear();
    chk(8'(ovf), 8'h00);
    for (int k = 0; k < 3; k++) begin
      u_serial_peer.xfer(8'h5a ^ 8'(k), 1'b0);
      pop(d);
      chk(d, 8'h5a ^ 8'(k));
    end
    chk(8'(ovf), 8'h00);
  endtask
  task automatic t_i2c;
    logic [7:0] d;
    cfg(1'b1, 1'b1, 1'b0, 4'h0);
    chk(8'(poe), 8'h04);
    chk(8'(pout & 4'hc), 8'h08);
    for (int k = 1; k < 4; k++) u_serial_peer.xfer(8'h11 * 8'(k), 1'b1);
    repeat (8) @(negedge i_clk);
    chk(8'(ovf), 8'h01);
    pop(d);
    chk(d, 8'h11);
    pop(d);
    chk(d, 8'h22);
    clear();
  endtask
  // buffer full in master: further writes wait, overflow never set
  task automatic t_master;
    logic [7:0] d;
    int k;
    cfg(1'b1, 1'b0, 1'b1, 4'h5);
    chk(8'(poe), 8'h05);
    put(8'h5a);
    chk(8'(txr), 8'h00);
    wait_rx();
    put(8'hc3);
    @(negedge i_clk);
    chk(8'(pout), 8'h04);
    @(posedge i_clk) txv <= 1'b1;
    for (k = 0; k < 200 && txr !== 1'b1; k++) @(negedge i_clk);
    chk(8'(k), 8'hc8);
    chk(8'(ovf), 8'h00);
    @(posedge i_clk) txv <= 1'b0;
    pop(d);
    chk(d, 8'hff);
    pop(d);
    chk(d, 8'hff);
    cfg(1'b0, 1'b0, 1'b0, 4'h0);
    chk(8'(poe), 8'h05);
    chk(8'(pout), 8'h0a);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {i_clk, i_arst_n, en, i2c, mst, clr, txv, rxr} = '0;
    dir = 4'h0;
    gout = 4'ha;
    goe = 4'h5;
    txd = 8'h00;
    repeat (12) @(negedge i_clk);
    chk(8'(poe), 8'h00);
    @(posedge i_clk) i_arst_n <= 1'b1;
    repeat (4) @(negedge i_clk);
    chk(8'(poe), 8'h05);
    t_spi_slave();
    t_i2c();
    t_master();
    final_report();
  end
endmodule // tb_top
